// [dv/lt_frame_tx_properties.sv]
// Concurrent checks on the serial lane of the training frame transmitter
`timescale 1ns/1ps
`default_nettype none

module lt_frame_tx_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial lane
    input wire logic tx_line_o,
    input wire logic tx_sof_o
);
    // ------------------------------------------------------------
    // Helper logic: position in frame and recent lane history
    // ------------------------------------------------------------
    logic [12:0] cnt;
    logic [30:0] sh;
    logic started;
    wire [12:0] pos = tx_sof_o ? 13'h0000 : cnt;
    wire frm = started | tx_sof_o;

    // Position counts from the start pulse; history holds the last 31 bits
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 13'h0000;
            sh <= 31'h00000000;
            started <= 1'b0;
        end else begin
            cnt <= pos + 13'h0001;
            sh <= {sh[29:0], tx_line_o};
            started <= started | tx_sof_o;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence ones8;
        tx_line_o [*8];
    endsequence

    sequence zeros8;
        !tx_line_o [*8];
    endsequence

    marker_shape_a: assert property (tx_sof_o |-> ones8 ##1 ones8 ##1 zeros8 ##1 zeros8)
        else $error("marker is not sixteen ones then sixteen zeros");
    sof_pulse_a: assert property (tx_sof_o |=> !tx_sof_o)
        else $error("start pulse longer than one bit");
    frame_period_a: assert property (tx_sof_o && started |-> cnt == 13'h1120)
        else $error("frame length is not 4384 bits");
    // Runs of ones in the other fields are at most eleven, so only the marker can match
    marker_unique_a: assert property ({sh, tx_line_o} == 32'hFFFF0000
        |-> frm && pos == 13'h001F)
        else $error("marker pattern seen outside the marker");
    dme_edge_a: assert property (frm && pos >= 32 && pos < 288 && pos[2:0] == 3'h0
        |-> tx_line_o != $past(tx_line_o))
        else $error("control cell does not start with a transition");
    dme_hold_a: assert property (frm && pos >= 32 && pos < 288 && pos[1:0] != 2'h0
        |-> $stable(tx_line_o))
        else $error("control half cell not held for four bits");
    prbs_recur_a: assert property (frm && pos >= 299 && pos < 4382
        |-> tx_line_o == (sh[10] ^ sh[8]))
        else $error("training bit breaks the pattern recurrence");
    tail_zero_a: assert property (frm && pos == 13'h111E |-> !tx_line_o ##1 !tx_line_o)
        else $error("frame tail is not two zeros");
endmodule

`default_nettype wire

// [dv/lt_link_partner.sv]
// Receiving link partner model: decodes and checks each training frame
`timescale 1ns/1ps
`default_nettype none

module lt_link_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Lane from the transmitter
    input wire logic line_i,
    input wire logic sof_i,
    // Decoded frame content
    output logic [15:0] coef_o,
    output logic [15:0] stat_o,
    output logic [10:0] head_o,
    output logic [31:0] frames_o,
    output logic [31:0] errs_o
);
    logic [0:287] hdr;
    logic [10:0] hist;
    logic [31:0] pos;
    logic [31:0] seen;
    logic started;

    // Sample mid-bit so the transmitter's edge never races the receiver
    always @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos = 0;
            seen = 0;
            started = 0;
            hist = 11'h000;
            frames_o = 0;
            errs_o = 0;
        end else begin
            pos = sof_i ? 0 : pos + 1;
            started = started | sof_i;
            if (started) begin
                if (pos < 288) hdr[pos] = line_i;
                if (pos < 32 && line_i !== (pos < 16)) errs_o = errs_o + 1;
                // Pattern history spans frames, so a reload would show
                if (pos >= 288 && pos < 4382) begin
                    if (pos < 299) head_o[298 - pos] = line_i;
                    if (seen >= 11 && line_i !== (hist[10] ^ hist[8])) errs_o = errs_o + 1;
                    hist = {hist[9:0], line_i};
                    seen = seen + 1;
                end
                if (pos >= 4382 && line_i !== 1'b0) errs_o = errs_o + 1;
                if (pos > 4383) errs_o = errs_o + 1;
                // A one toggles mid-cell, so compare half cells
                if (pos == 298) begin
                    for (int b = 0; b < 16; b++) begin
                        coef_o[15 - b] = hdr[36 + 8 * b] ^ hdr[32 + 8 * b];
                        stat_o[15 - b] = hdr[164 + 8 * b] ^ hdr[160 + 8 * b];
                    end
                    frames_o = frames_o + 1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// [dv/test_link_training_frame_tx.sv]
// Self-checking testbench for the link training frame transmitter
`timescale 1ns/1ps
`default_nettype none

`include "lt_frame_defines.vh"

module test_link_training_frame_tx;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000;
    wire [31:0] prdata_o;
    wire pready_o;
    wire pslverr_o;
    wire tx_line_o;
    wire tx_sof_o;
    wire [15:0] coef_rx;
    wire [15:0] stat_rx;
    wire [10:0] head_rx;
    wire [31:0] frames_rx;
    wire [31:0] errs_rx;
    int fails = 0;
    int checks = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] a;
    logic [1:0] ii;
    logic [10:0] seed = 11'h5A5;

    always #12.5 clk_i = ~clk_i;

    link_training_frame_tx dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .tx_line_o(tx_line_o), .tx_sof_o(tx_sof_o));

    lt_link_partner part (.clk_i(clk_i), .rst_n_i(rst_n_i), .line_i(tx_line_o),
        .sof_i(tx_sof_o), .coef_o(coef_rx), .stat_o(stat_rx), .head_o(head_rx),
        .frames_o(frames_rx), .errs_o(errs_rx));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task give_verdict;
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until ready is sampled high at a rising edge; outputs are
    // read there, before the design's own updates of that edge land
    task apb(input logic [7:0] addr, input logic wr, input logic [31:0] wdata);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wdata;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            fails++;
            give_verdict;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Reserved bits are written as ones; all four codes reach every tap over four frames
    task set_words(input logic [1:0] k);
        apb(`LT_REG_COEF, 1'b1, {16'h0000, 2'b11, k[0], k[1], 6'h3F, k, k + 2'h1, k + 2'h2});
        apb(`LT_REG_STAT, 1'b1, {16'h0000, k[0], 9'h1FF, k, k + 2'h1, k + 2'h2});
    endtask

    // Words as the lane must carry them: reserved bits always zero
    function automatic logic [31:0] coef_exp(input logic [1:0] k);
        return {18'h0, k[0], k[1], 6'h0, k, k + 2'h1, k + 2'h2};
    endfunction

    function automatic logic [31:0] stat_exp(input logic [1:0] k);
        return {16'h0, k[0], 9'h0, k, k + 2'h1, k + 2'h2};
    endfunction

    function automatic logic [10:0] advance(input logic [10:0] s, input int n);
        for (int k = 0; k < n; k++) s = {s[9:0], s[10] ^ s[8]};
        return s;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (a = 8'h00; a <= 8'h10; a = a + 8'h04) begin
            apb(a, 1'b0, 32'h00000000);
            chk("reset value", rd, 32'h00000000);
        end
        apb(8'h14, 1'b0, 32'h00000000);
        chk("unmapped error", {31'h0, err}, 32'h00000001);
        chk("unmapped data", rd, 32'h00000000);
        apb(`LT_REG_SEED, 1'b1, {21'h0, seed});
        set_words(2'h0);
        apb(`LT_REG_COEF, 1'b0, 32'h00000000);
        chk("coef readback", rd, coef_exp(2'h0));
        apb(`LT_REG_CTRL, 1'b1, 32'h00000001);
        for (int i = 0; i < 4; i++) begin
            ii = i[1:0];
            n = 0;
            while (frames_rx !== i + 1 && n < 6000) begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 6000) begin
                fails++;
                give_verdict;
            end
            chk("coef word", {16'h0, coef_rx}, coef_exp(ii));
            chk("status word", {16'h0, stat_rx}, stat_exp(ii));
            chk("prbs head", {21'h0, head_rx}, {21'h0, advance(seed, 4094 * i)});
            // A second run request must not reload the seed
            if (i == 1) apb(`LT_REG_CTRL, 1'b1, 32'h00000001);
            // Updates go in after the header is out, keeping the hold window
            if (i < 3) set_words(ii + 2'h1);
        end
        // Early in the fourth frame's training field: three frames done
        apb(`LT_REG_STATE, 1'b0, 32'h00000000);
        chk("state running", rd, 32'h00030009);
        chk("partner errors", errs_rx, 32'h00000000);
        give_verdict;
    end
endmodule

bind link_training_frame_tx lt_frame_tx_properties props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .tx_line_o(tx_line_o), .tx_sof_o(tx_sof_o));

`default_nettype wire

// [verilog/link_training_frame_tx.v]
// Link training frame transmitter with APB control registers
`timescale 1ns/1ps
`default_nettype none

`include "lt_frame_defines.vh"

module link_training_frame_tx (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`LT_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Serial lane
    output reg tx_line_o,
    output reg tx_sof_o
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    reg run_enable;
    reg [`LT_SEED_W-1:0] training_prbs_seed;
    reg tx_preset_request;
    reg tx_init_request;
    reg [1:0] tx_post_tap_request;
    reg [1:0] tx_main_tap_request;
    reg [1:0] tx_pre_tap_request;
    reg rx_ready_report;
    reg [1:0] post_tap_state;
    reg [1:0] main_tap_state;
    reg [1:0] pre_tap_state;

    reg running;
    reg seed_was_zero;
    reg [`LT_CNT_W-1:0] bit_cnt;
    reg [15:0] frame_count;
    reg [15:0] coef_shadow;
    reg [15:0] stat_shadow;
    reg dme_level;

    reg next_line;
    reg next_dme;
    reg [31:0] next_rdata;
    reg next_err;

    wire [15:0] coef_word;
    wire [15:0] stat_word;
    wire in_marker;
    wire in_coef;
    wire in_stat;
    wire in_cc;
    wire in_prbs;
    wire in_tail;
    wire [`LT_CNT_W-1:0] cc_offset;
    wire [3:0] cell_index;
    wire [2:0] cell_pos;
    wire [15:0] cc_word;
    wire cc_data_bit;
    wire prbs_bit;
    wire start_frames;
    wire frame_wrap;
    wire apb_setup;
    wire apb_write;
    wire addr_mapped;

    // -------------------------------------------------------------
    // Control channel words
    // -------------------------------------------------------------
    // Reserved positions are hard zeros, whatever software wrote
    assign coef_word = {2'b00,
                        tx_preset_request,
                        tx_init_request,
                        6'b000000,
                        tx_post_tap_request,
                        tx_main_tap_request,
                        tx_pre_tap_request};

    // Receiver-ready flag and the three tap reports
    assign stat_word = {rx_ready_report,
                        9'b000000000,
                        post_tap_state,
                        main_tap_state,
                        pre_tap_state};

    // -------------------------------------------------------------
    // Frame segment decode
    // -------------------------------------------------------------
    // Segment order inside one frame
    assign in_marker = (bit_cnt < `LT_COEF_START);
    assign in_coef = (bit_cnt >= `LT_COEF_START) && (bit_cnt < `LT_STAT_START);
    assign in_stat = (bit_cnt >= `LT_STAT_START) && (bit_cnt < `LT_PRBS_START);
    assign in_prbs = (bit_cnt >= `LT_PRBS_START) && (bit_cnt < `LT_TAIL_START);
    assign in_tail = (bit_cnt >= `LT_TAIL_START);
    assign in_cc = in_coef | in_stat;

    // Offset of the current bit inside its control field
    assign cc_offset = in_coef ? (bit_cnt - `LT_COEF_START) : (bit_cnt - `LT_STAT_START);

    // Eight line bits per data bit: 16 cells fill 128 bit times
    assign cell_index = cc_offset[6:3];
    assign cell_pos = cc_offset[2:0];

    // Most significant bit goes out first
    assign cc_word = in_coef ? coef_shadow : stat_shadow;
    assign cc_data_bit = cc_word[`LT_WORD_MSB - cell_index];

    // Frame boundary
    assign frame_wrap = (bit_cnt == `LT_FRAME_LAST);

    // -------------------------------------------------------------
    // Training pattern generator
    // -------------------------------------------------------------
    // Seed is loaded only when transmission starts; the generator
    // then keeps its state across frames but not across stop/start:
    // a new start reloads it.
    lt_prbs11 u_prbs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(start_frames),
        .seed_i(training_prbs_seed),
        .step_i(running & in_prbs),
        .bit_o(prbs_bit)
    );

    // -------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------
    // Zero wait states: ready is raised during setup so it is
    // already high in the access cycle, and comes from a flop.
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i;
    assign addr_mapped = (paddr_i == `LT_REG_CTRL) ||
                         (paddr_i == `LT_REG_SEED) ||
                         (paddr_i == `LT_REG_COEF) ||
                         (paddr_i == `LT_REG_STAT) ||
                         (paddr_i == `LT_REG_STATE);

    // Run bit rising while idle starts the frame stream
    assign start_frames = apb_write && ~pslverr_o && (paddr_i == `LT_REG_CTRL) &&
                          pwdata_i[`LT_CTRL_RUN] && ~running;

    // -------------------------------------------------------------
    // Software registers
    // -------------------------------------------------------------
    // Writes land only in the access cycle with ready high
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_enable <= 1'b0;
            training_prbs_seed <= `LT_SEED_ZERO;
            tx_preset_request <= 1'b0;
            tx_init_request <= 1'b0;
            tx_post_tap_request <= 2'b00;
            tx_main_tap_request <= 2'b00;
            tx_pre_tap_request <= 2'b00;
            rx_ready_report <= 1'b0;
            post_tap_state <= 2'b00;
            main_tap_state <= 2'b00;
            pre_tap_state <= 2'b00;
        end else if (apb_write && ~pslverr_o) begin
            case (paddr_i)
                `LT_REG_CTRL: begin
                    run_enable <= pwdata_i[`LT_CTRL_RUN];
                end
                `LT_REG_SEED: begin
                    training_prbs_seed <= pwdata_i[`LT_SEED_W-1:0];
                end
                `LT_REG_COEF: begin
                    tx_preset_request <= pwdata_i[`LT_COEF_PRESET];
                    tx_init_request <= pwdata_i[`LT_COEF_INIT];
                    tx_post_tap_request <= pwdata_i[5:4];
                    tx_main_tap_request <= pwdata_i[3:2];
                    tx_pre_tap_request <= pwdata_i[1:0];
                end
                `LT_REG_STAT: begin
                    rx_ready_report <= pwdata_i[`LT_STAT_READY];
                    post_tap_state <= pwdata_i[5:4];
                    main_tap_state <= pwdata_i[3:2];
                    pre_tap_state <= pwdata_i[1:0];
                end
                default: begin
                    run_enable <= run_enable;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Read data mux
    // -------------------------------------------------------------
    // Unmapped addresses read zero and flag a slave error
    always @* begin
        next_rdata = `LT_DATA_ZERO;
        next_err = 1'b0;
        case (paddr_i)
            `LT_REG_CTRL: begin
                next_rdata[`LT_CTRL_RUN] = run_enable;
            end
            `LT_REG_SEED: begin
                next_rdata[`LT_SEED_W-1:0] = training_prbs_seed;
            end
            `LT_REG_COEF: begin
                next_rdata[15:0] = coef_word & `LT_COEF_MASK;
            end
            `LT_REG_STAT: begin
                next_rdata[15:0] = stat_word & `LT_STAT_MASK;
            end
            `LT_REG_STATE: begin
                next_rdata[`LT_STATE_RUN] = running;
                next_rdata[`LT_STATE_SEED0] = seed_was_zero;
                next_rdata[`LT_STATE_CC] = running & in_cc;
                next_rdata[`LT_STATE_PRBS] = running & (in_prbs | in_tail);
                next_rdata[31:16] = frame_count;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // Answer registered in setup, presented in access
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= `LT_DATA_ZERO;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (apb_setup) begin
            prdata_o <= pwrite_i ? `LT_DATA_ZERO : next_rdata;
            pready_o <= 1'b1;
            pslverr_o <= next_err | ~addr_mapped;
        end else begin
            prdata_o <= `LT_DATA_ZERO;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // Frame sequencer
    // -------------------------------------------------------------
    // One line bit per clock; the count wraps after the last bit
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            running <= 1'b0;
            bit_cnt <= `LT_MARK_START;
            frame_count <= `LT_WORD_ZERO;
            seed_was_zero <= 1'b0;
        end else if (start_frames) begin
            running <= 1'b1;
            bit_cnt <= `LT_MARK_START;
            frame_count <= `LT_WORD_ZERO;
            seed_was_zero <= (training_prbs_seed == `LT_SEED_ZERO);
        end else if (!run_enable) begin
            // Stop is immediate; a partial frame is abandoned
            running <= 1'b0;
            bit_cnt <= `LT_MARK_START;
        end else if (running) begin
            if (frame_wrap) begin
                bit_cnt <= `LT_MARK_START;
                frame_count <= frame_count + 16'h0001;
            end else begin
                bit_cnt <= bit_cnt + 13'h0001;
            end
        end
    end

    // -------------------------------------------------------------
    // Control channel snapshot
    // -------------------------------------------------------------
    // Captured at frame start so a mid-field write cannot tear a
    // word; software changes show up in the next frame.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coef_shadow <= `LT_WORD_ZERO;
            stat_shadow <= `LT_WORD_ZERO;
        end else if (bit_cnt == `LT_MARK_START) begin
            coef_shadow <= coef_word;
            stat_shadow <= stat_word;
        end
    end

    // -------------------------------------------------------------
    // Manchester encoder
    // -------------------------------------------------------------
    // Level flips at every cell edge, and again mid-cell for a one.
    // Runs stay at most eight bits, so the marker cannot recur.
    always @* begin
        next_dme = dme_level;
        if (cell_pos == `LT_CELL_FIRST) begin
            next_dme = ~dme_level;
        end else if ((cell_pos == `LT_CELL_MID) && cc_data_bit) begin
            next_dme = ~dme_level;
        end
    end

    // Level resets low in the marker, matching its last half
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dme_level <= 1'b0;
        end else if (running && in_cc) begin
            dme_level <= next_dme;
        end else begin
            dme_level <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // Line bit selection
    // -------------------------------------------------------------
    always @* begin
        next_line = 1'b0;
        if (running) begin
            if (in_marker) begin
                next_line = (bit_cnt < `LT_MARK_HALF);
            end else if (in_cc) begin
                next_line = next_dme;
            end else if (in_prbs) begin
                next_line = prbs_bit;
            end else begin
                next_line = 1'b0;
            end
        end
    end

    // Serial output and frame-start pulse, both registered
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_line_o <= 1'b0;
            tx_sof_o <= 1'b0;
        end else begin
            tx_line_o <= next_line;
            tx_sof_o <= running && run_enable && (bit_cnt == `LT_MARK_START);
        end
    end

endmodule

`default_nettype wire

// [verilog/lt_frame_defines.vh]
// Constants for the link training frame transmitter
`ifndef LT_FRAME_DEFINES_VH
`define LT_FRAME_DEFINES_VH

// -----------------------------------------------------------------
// Frame layout, in line bit times
// -----------------------------------------------------------------
`define LT_CNT_W 13
`define LT_FRAME_BITS 13'h1120
`define LT_FRAME_LAST 13'h111F
`define LT_MARK_START 13'h0000
`define LT_MARK_HALF 13'h0010
`define LT_COEF_START 13'h0020
`define LT_STAT_START 13'h00A0
`define LT_PRBS_START 13'h0120
`define LT_TAIL_START 13'h111E

// -----------------------------------------------------------------
// Control channel cell shape
// -----------------------------------------------------------------
`define LT_CELL_FIRST 3'h0
`define LT_CELL_MID 3'h4
`define LT_WORD_MSB 4'hF

// -----------------------------------------------------------------
// Pattern generator
// -----------------------------------------------------------------
`define LT_SEED_W 11
`define LT_SEED_ZERO 11'h000

// -----------------------------------------------------------------
// APB register map, byte addresses
// -----------------------------------------------------------------
`define LT_ADDR_W 8
`define LT_REG_CTRL 8'h00
`define LT_REG_SEED 8'h04
`define LT_REG_COEF 8'h08
`define LT_REG_STAT 8'h0C
`define LT_REG_STATE 8'h10

// -----------------------------------------------------------------
// Register fields and masks
// -----------------------------------------------------------------
`define LT_CTRL_RUN 0
`define LT_COEF_PRESET 13
`define LT_COEF_INIT 12
`define LT_STAT_READY 15
`define LT_COEF_MASK 16'h303F
`define LT_STAT_MASK 16'h803F
`define LT_STATE_RUN 0
`define LT_STATE_SEED0 1
`define LT_STATE_CC 2
`define LT_STATE_PRBS 3
`define LT_WORD_ZERO 16'h0000
`define LT_DATA_ZERO 32'h00000000

`endif

// [verilog/lt_prbs11.v]
// Eleven-stage training pattern generator, 1 + x9 + x11
`timescale 1ns/1ps
`default_nettype none

`include "lt_frame_defines.vh"

module lt_prbs11 (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Control
    input wire load_i,
    input wire [`LT_SEED_W-1:0] seed_i,
    input wire step_i,
    // Pattern
    output wire bit_o
);

    // -------------------------------------------------------------
    // Shift register
    // -------------------------------------------------------------
    reg [`LT_SEED_W-1:0] state;
    wire feedback;

    // Taps at stages 11 and 9
    assign feedback = state[10] ^ state[8];
    assign bit_o = state[10];

    // Load on every load_i pulse, then step only while step_i is high; never reloaded between frames
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= `LT_SEED_ZERO;
        end else if (load_i) begin
            state <= seed_i;
        end else if (step_i) begin
            state <= {state[9:0], feedback};
        end
    end

endmodule

`default_nettype wire
